// *** hdl/itoc_top.sv ***
// Interrupt control, option register, main timer and shared prescaler with APB access
`timescale 1ns/1ps
`include "itoc_defines.svh"

module itoc_top
  import itoc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_clock_pin,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_a_pins,
  input wire logic [7:0] port_b_latch,
  input wire logic cmp_event,
  input wire logic wdt_tick,
  output logic [7:0] pullup_en,
  output logic wdt_timeout,
  output logic core_irq,
  output logic irq
);

  // ==========================================================
  // Helper functions

  // Address decode shared by the read and write paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [8:0] idx);
    reg_hit = (addr[10:2] == idx);
  endfunction

  // Prescaler terminal mask: timer divides by 2^(rate+1), watchdog by 2^rate
  function automatic logic [7:0] rate_mask(input logic [2:0] rate, input logic for_wdt);
    logic [8:0] span;
    span = for_wdt ? (9'h001 << rate) : (9'h002 << rate);
    rate_mask = 8'(span - 9'h001);
  endfunction

  // ==========================================================
  // State and pin synchronisers
  itoc_state_s st_ff;     // Registered state
  itoc_state_s nxt_st;    // Next state
  itoc_ev_s ev;           // Events of this cycle
  logic [5:0] pins_sync;  // Filtered {port nibble, ext pin, timer pin}
  logic acc_done;         // Access completes at this edge
  logic wr_en;            // Write takes effect at this edge
  logic wr_tmr;           // Software writes the main timer
  logic mapped;           // Address hits a register
  logic src_tick;         // Timer clock source event
  logic psc_in;           // Prescaler input event
  logic psc_hit;          // Prescaler at terminal count
  logic tmr_inc;          // Timer increments this cycle
  logic [7:0] psc_mask;   // Active prescaler mask

  itoc_sync #(
    .WIDTH(6)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_async({port_b_a_pins, ext_irq_pin, timer_clock_pin}),
    .pin_stable(pins_sync)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    // Answer one cycle into the access phase, then commit on that edge
    acc_done = psel & penable & st_ff.pready;
    wr_en = acc_done & pwrite;
    mapped = reg_hit(paddr, `ITOC_IDX_TIMER) | reg_hit(paddr, `ITOC_IDX_INTCTL) |
             reg_hit(paddr, `ITOC_IDX_PERFLAG) | reg_hit(paddr, `ITOC_IDX_OPTION) |
             reg_hit(paddr, `ITOC_IDX_PEREN) | reg_hit(paddr, `ITOC_IDX_IRQ_STAT) |
             reg_hit(paddr, `ITOC_IDX_IRQ_MASK);
    wr_tmr = wr_en & reg_hit(paddr, `ITOC_IDX_TIMER);
    nxt_st.pready = psel & penable & ~st_ff.pready;
    nxt_st.pslverr = psel & penable & ~st_ff.pready & ~mapped;

    // Timer source: pin edge chosen by the edge bit, or every cycle
    nxt_st.tpin_d = pins_sync[0];
    if (st_ff.option[`ITOC_OPT_CLK_SRC]) begin
      src_tick = st_ff.option[`ITOC_OPT_CLK_EDGE] ? (st_ff.tpin_d & ~pins_sync[0])
                                                  : (~st_ff.tpin_d & pins_sync[0]);
    end else begin
      src_tick = 1'b1;
    end

    // Shared prescaler: watchdog when assigned, timer otherwise
    psc_mask = rate_mask(st_ff.option[`ITOC_OPT_RATE_HI:`ITOC_OPT_RATE_LO],
                         st_ff.option[`ITOC_OPT_PSC_ASSIGN]);
    psc_hit = ((st_ff.presc & psc_mask) == psc_mask);
    if (st_ff.option[`ITOC_OPT_PSC_ASSIGN]) begin
      psc_in = wdt_tick;
      tmr_inc = src_tick;
    end else begin
      psc_in = src_tick;
      tmr_inc = src_tick & psc_hit;
    end
    nxt_st.wdt_timeout = st_ff.option[`ITOC_OPT_PSC_ASSIGN] & wdt_tick & psc_hit;
    if (psc_in) begin
      nxt_st.presc = st_ff.presc + 8'h01;
    end

    // Main timer; a software write also restarts the prescaler
    if (wr_tmr) begin
      nxt_st.main_timer = pwdata[7:0];
      nxt_st.presc = 8'h00;
    end else if (tmr_inc) begin
      nxt_st.main_timer = st_ff.main_timer + 8'h01;
    end

    // Source events, independent of every enable bit
    ev.tmr = tmr_inc & ~wr_tmr & (st_ff.main_timer == 8'hff);
    ev.ext = st_ff.option[`ITOC_OPT_EXT_EDGE] ? (~st_ff.epin_d & pins_sync[1])
                                               : (st_ff.epin_d & ~pins_sync[1]);
    ev.port = (pins_sync[5:2] != st_ff.port_d);
    ev.cmp = cmp_event;
    nxt_st.epin_d = pins_sync[1];
    nxt_st.port_d = pins_sync[5:2];

    // Register writes; a hardware set in the same cycle wins
    if (wr_en) begin
      if (reg_hit(paddr, `ITOC_IDX_INTCTL)) begin
        nxt_st.intctl = pwdata[7:0];
      end
      if (reg_hit(paddr, `ITOC_IDX_OPTION)) begin
        nxt_st.option = pwdata[7:0];
      end
      if (reg_hit(paddr, `ITOC_IDX_PEREN)) begin
        nxt_st.cmp_en = pwdata[`ITOC_PER_CMP];
      end
      if (reg_hit(paddr, `ITOC_IDX_PERFLAG)) begin
        nxt_st.cmp_flag = pwdata[`ITOC_PER_CMP];
      end
      if (reg_hit(paddr, `ITOC_IDX_IRQ_STAT)) begin
        nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[3:0];
      end
      if (reg_hit(paddr, `ITOC_IDX_IRQ_MASK)) begin
        nxt_st.irq_mask = pwdata[3:0];
      end
    end
    nxt_st.intctl[`ITOC_INT_TIF] = nxt_st.intctl[`ITOC_INT_TIF] | ev.tmr;
    nxt_st.intctl[`ITOC_INT_EIF] = nxt_st.intctl[`ITOC_INT_EIF] | ev.ext;
    nxt_st.intctl[`ITOC_INT_PCIF] = nxt_st.intctl[`ITOC_INT_PCIF] | ev.port;
    nxt_st.cmp_flag = nxt_st.cmp_flag | ev.cmp;
    nxt_st.irq_stat = nxt_st.irq_stat | ev;

    // Read data, captured with the answer
    if (psel & penable & ~st_ff.pready & ~pwrite) begin
      if (reg_hit(paddr, `ITOC_IDX_INTCTL)) begin
        nxt_st.prdata = {24'h000000, st_ff.intctl};
      end else if (reg_hit(paddr, `ITOC_IDX_OPTION)) begin
        nxt_st.prdata = {24'h000000, st_ff.option};
      end else if (reg_hit(paddr, `ITOC_IDX_TIMER)) begin
        nxt_st.prdata = {24'h000000, st_ff.main_timer};
      end else if (reg_hit(paddr, `ITOC_IDX_PEREN)) begin
        nxt_st.prdata = {31'h00000000, st_ff.cmp_en};
      end else if (reg_hit(paddr, `ITOC_IDX_PERFLAG)) begin
        nxt_st.prdata = {31'h00000000, st_ff.cmp_flag};
      end else if (reg_hit(paddr, `ITOC_IDX_IRQ_STAT)) begin
        nxt_st.prdata = {28'h0000000, st_ff.irq_stat};
      end else if (reg_hit(paddr, `ITOC_IDX_IRQ_MASK)) begin
        nxt_st.prdata = {28'h0000000, st_ff.irq_mask};
      end else begin
        nxt_st.prdata = 32'h00000000;
      end
    end

    // Core request: enabled flags, all gated by the global enable
    nxt_st.core_irq = nxt_st.intctl[`ITOC_INT_GIE] &
      ((nxt_st.intctl[`ITOC_INT_TIE] & nxt_st.intctl[`ITOC_INT_TIF]) |
       (nxt_st.intctl[`ITOC_INT_EIE] & nxt_st.intctl[`ITOC_INT_EIF]) |
       (nxt_st.intctl[`ITOC_INT_PCIE] & nxt_st.intctl[`ITOC_INT_PCIF]) |
       (nxt_st.intctl[`ITOC_INT_PERIPHERAL_IRQ_ENABLE] & nxt_st.cmp_en & nxt_st.cmp_flag));
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

    // Pull-ups follow the port latch unless globally disabled
    nxt_st.pullup_en = st_ff.option[`ITOC_OPT_PULLUP_DIS] ? 8'h00 : port_b_latch;
  end

  // ==========================================================
  // State register; clock enable low freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.option <= `ITOC_RST_OPTION;
      st_ff.intctl <= `ITOC_RST_INTCTL;
      st_ff.main_timer <= `ITOC_RST_TIMER;
      st_ff.irq_mask <= `ITOC_RST_MASK;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign pullup_en = st_ff.pullup_en;
  assign wdt_timeout = st_ff.wdt_timeout;
  assign core_irq = st_ff.core_irq;
  assign irq = st_ff.irq;

  // ==========================================================
  // Assertions
  AST_PULLUP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && st_ff.option[`ITOC_OPT_PULLUP_DIS]) |=> (pullup_en == 8'h00))
    else $error("Pull-up enabled while disabled globally");

  AST_PULLUP_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !st_ff.option[`ITOC_OPT_PULLUP_DIS]) |=> (pullup_en == $past(port_b_latch)))
    else $error("Pull-up does not follow port latch");

  AST_TMR_INTERNAL: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !st_ff.option[`ITOC_OPT_CLK_SRC] && st_ff.option[`ITOC_OPT_PSC_ASSIGN] && !wr_tmr)
      |=> (st_ff.main_timer == 8'($past(st_ff.main_timer) + 8'h01)))
    else $error("Timer missed an instruction-cycle increment");

  AST_TMR_PIN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && st_ff.option[`ITOC_OPT_CLK_SRC] && (pins_sync[0] == st_ff.tpin_d) && !wr_tmr)
      |=> $stable(st_ff.main_timer))
    else $error("Timer moved without a pin transition");

  AST_TMR_DIV2: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !st_ff.option[`ITOC_OPT_CLK_SRC] && st_ff.option[3:0] == 4'h0 && !wr_tmr
     && st_ff.presc[0] == 1'b0) |=> $stable(st_ff.main_timer))
    else $error("Timer ran faster than divide-by-two");

  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ev.tmr) |=> st_ff.intctl[`ITOC_INT_TIF])
    else $error("Overflow flag not set on rollover");

  AST_GIE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    core_irq |-> st_ff.intctl[`ITOC_INT_GIE])
    else $error("Core request without global enable");

  AST_INTCTL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && wr_en && reg_hit(paddr, `ITOC_IDX_INTCTL) && ev == 4'h0)
      |=> (st_ff.intctl == $past(pwdata[7:0])))
    else $error("Control register write lost");

  AST_CMP_EN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && wr_en && reg_hit(paddr, `ITOC_IDX_PEREN)) |=> (st_ff.cmp_en == $past(pwdata[0])))
    else $error("Comparator enable write lost");

  AST_WDT_DIRECT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && st_ff.option[3:0] == 4'h8 && wdt_tick) |=> wdt_timeout)
    else $error("Watchdog tick not passed at 1:1");

  AST_CMP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cmp_event) |=> st_ff.cmp_flag)
    else $error("Comparator flag not set");

  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && psel && penable && !pready) |=> pready ##1 !pready)
    else $error("Answer not given one cycle into access");

  COV_CORE_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(core_irq));
  COV_TMR_WRAP: cover property (@(posedge pclk) disable iff (!presetn) ce && ev.tmr);
  COV_WDT_OUT: cover property (@(posedge pclk) disable iff (!presetn) $rose(wdt_timeout));
  COV_UNMAPPED: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
  COV_PIN_TICK: cover property (@(posedge pclk) disable iff (!presetn) ce && src_tick && st_ff.option[`ITOC_OPT_CLK_SRC]);

  // Pin events reach their flags one edge after the filtered edge is seen
  AST_EXT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ev.ext) |=> st_ff.intctl[`ITOC_INT_EIF])
    else $error("External flag not set on pin edge");

  AST_PORT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ev.port) |=> st_ff.intctl[`ITOC_INT_PCIF])
    else $error("Port change flag not set");

  // The watchdog path must stay silent while the prescaler belongs to the timer
  AST_WDT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !st_ff.option[`ITOC_OPT_PSC_ASSIGN]) |=> !wdt_timeout)
    else $error("Watchdog output while prescaler serves the timer");

  AST_CORE_IRQ_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !wr_en && st_ff.intctl[`ITOC_INT_GIE] && st_ff.intctl[`ITOC_INT_PERIPHERAL_IRQ_ENABLE] && st_ff.cmp_en
     && st_ff.cmp_flag) |=> core_irq)
    else $error("Enabled comparator flag did not reach the core");

  AST_TMR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && wr_tmr) |=> (st_ff.main_timer == $past(pwdata[7:0])))
    else $error("Timer write lost");

endmodule

// *** hdl/itoc_defines.svh ***
// Register indexes, field positions, reset values and synchroniser depth of the interrupt/option block
`ifndef ITOC_DEFINES_SVH
`define ITOC_DEFINES_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define ITOC_IDX_TIMER     9'h001
`define ITOC_IDX_INTCTL    9'h00b
`define ITOC_IDX_PERFLAG   9'h00c
`define ITOC_IDX_OPTION    9'h081
`define ITOC_IDX_PEREN     9'h08c
`define ITOC_IDX_IRQ_STAT  9'h0a0
`define ITOC_IDX_IRQ_MASK  9'h0a1

// ==========================================================
// Option register fields
`define ITOC_OPT_PULLUP_DIS  7
`define ITOC_OPT_EXT_EDGE    6
`define ITOC_OPT_CLK_SRC     5
`define ITOC_OPT_CLK_EDGE    4
`define ITOC_OPT_PSC_ASSIGN  3
`define ITOC_OPT_RATE_HI     2
`define ITOC_OPT_RATE_LO     0

// ==========================================================
// Interrupt control register fields
`define ITOC_INT_GIE   7
`define ITOC_INT_PERIPHERAL_IRQ_ENABLE  6
`define ITOC_INT_TIE   5
`define ITOC_INT_EIE   4
`define ITOC_INT_PCIE  3
`define ITOC_INT_TIF   2
`define ITOC_INT_EIF   1
`define ITOC_INT_PCIF  0

// Comparator enable / flag position in the peripheral registers
`define ITOC_PER_CMP   0

// ==========================================================
// Reset values
`define ITOC_RST_OPTION  8'hff
`define ITOC_RST_INTCTL  8'h00
`define ITOC_RST_TIMER   8'h00
`define ITOC_RST_MASK    4'h0

// Synchroniser depth for pins from outside the clock domain
`define ITOC_SYNC_STAGES 3

`endif

// *** hdl/itoc_pkg.sv ***
// Types shared by the interrupt/option control block
package itoc_pkg;

  // ==========================================================
  // Event vector, one bit per interrupt source (bit order = status bits)
  typedef struct packed {
    logic cmp;   // Comparator condition
    logic port;  // Port B upper nibble changed
    logic ext;   // External interrupt pin edge
    logic tmr;   // Main timer rolled over
  } itoc_ev_s;

  // ==========================================================
  // Whole state of the top module, registered as one vector
  typedef struct packed {
    logic [7:0] option;       // Timer / prescaler / pull-up options
    logic [7:0] intctl;       // Core interrupt enables and flags
    logic [7:0] main_timer;   // Eight-bit main timer
    logic [7:0] presc;        // Shared prescaler counter
    logic cmp_en;             // Comparator interrupt enable
    logic cmp_flag;           // Comparator interrupt flag
    logic [3:0] irq_stat;     // Sticky event status
    logic [3:0] irq_mask;     // Event mask
    logic [31:0] prdata;      // Registered read data
    logic pready;             // Access-phase answer
    logic pslverr;            // Unmapped address answer
    logic irq;                // Status/mask interrupt line
    logic core_irq;           // Request to the processor core
    logic [7:0] pullup_en;    // Weak pull-up enables
    logic wdt_timeout;        // Divided watchdog tick
    logic tpin_d;             // Last stable timer pin level
    logic epin_d;             // Last stable external irq pin level
    logic [3:0] port_d;       // Last stable port nibble
  } itoc_state_s;

endpackage

// *** hdl/itoc_sync.sv ***
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module itoc_sync #(
  parameter int WIDTH = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_stable
);

  // ==========================================================
  // One filtered lane per bit
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_lane
      logic s1_ff;      // Metastable stage, read only by s2
      logic s2_ff;      // Second stage
      logic s3_ff;      // Third stage
      logic stable_ff;  // Accepted level

      // Shift chain; a change is taken once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          stable_ff <= 1'b0;
        end else if (ce) begin
          s1_ff <= pin_async[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          // Agreement filter rejects a single-cycle glitch past stage one
          if (s2_ff == s3_ff) begin
            stable_ff <= s3_ff;
          end
        end
      end

      assign pin_stable[gi] = stable_ff;
    end
  endgenerate

endmodule

// *** verification/itoc_partner.sv ***
// Behavioural model of the pins and event sources around the interrupt block
`timescale 1ns/1ps
module itoc_partner (
  input wire logic pclk,
  output logic timer_clock_pin,
  output logic ext_irq_pin,
  output logic [3:0] port_b_a_pins,
  output logic cmp_event,
  output logic wdt_tick
);
  // ==========================================================
  // Idle levels: pins low, no event pulses
  initial begin
    timer_clock_pin = 1'b0;
    ext_irq_pin = 1'b0;
    port_b_a_pins = 4'h0;
    cmp_event = 1'b0;
    wdt_tick = 1'b0;
  end

  // Each level held six cycles so the filtered synchroniser sees it
  task automatic pin_pulses(input int n);
    repeat (n) begin
      repeat (6) @(posedge pclk);
      timer_clock_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      timer_clock_pin <= 1'b0;
    end
  endtask

  // Static levels on the external and port pins
  task automatic set_pins(input logic e, input logic [3:0] p);
    @(posedge pclk);
    ext_irq_pin <= e;
    port_b_a_pins <= p;
  endtask

  // One-cycle comparator condition, raised whatever the enables
  task automatic cmp_pulse();
    @(posedge pclk);
    cmp_event <= 1'b1;
    @(posedge pclk);
    cmp_event <= 1'b0;
  endtask

  // Watchdog oscillator ticks, one every second cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      wdt_tick <= 1'b1;
      @(posedge pclk);
      wdt_tick <= 1'b0;
    end
  endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the interrupt and option control block
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Byte addresses of the registers
  localparam logic [11:0] A_TMR = 12'h004, A_INT = 12'h02c, A_PF = 12'h030, A_OPT = 12'h204;
  localparam logic [11:0] A_PE = 12'h230, A_ST = 12'h280, A_MK = 12'h284;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, v1;
  logic [7:0] port_b_latch, pullup_en, mv;
  logic wdt_timeout, core_irq, irq, tpin, epin, cmp_ev, wtick;
  logic [3:0] ppins;
  logic [7:0] exp_q[$];
  int failures, cmp_count, cyc, wdt_cnt, seed, t1, rtime, i, r, dt, d, n0;

  itoc_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_clock_pin(tpin), .ext_irq_pin(epin), .port_b_a_pins(ppins),
    .port_b_latch(port_b_latch), .cmp_event(cmp_ev), .wdt_tick(wtick), .pullup_en(pullup_en),
    .wdt_timeout(wdt_timeout), .core_irq(core_irq), .irq(irq));
  itoc_partner P (.pclk(pclk), .timer_clock_pin(tpin), .ext_irq_pin(epin),
    .port_b_a_pins(ppins), .cmp_event(cmp_ev), .wdt_tick(wtick));

  // ==========================================================
  // Clock, cycle count and watchdog output pulse count
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wdt_timeout === 1'b1) wdt_cnt <= wdt_cnt + 1;
  end

  // Verdict, printed once at the end or when a wait runs out
  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Four-state compare; an unknown matches only an unknown in the same bit
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // APB transfer; an idle edge first so psel never toggles twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dd);
    int k;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= dd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata; rerr = pslverr; rtime = cyc;
    psel <= 1'b0; penable <= 1'b0;
    if (k == 20) begin failures++; print_verdict(); end
  endtask

  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    port_b_latch = 0; seed = 24396; failures = 0; cmp_count = 0; cyc = 0; wdt_cnt = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("option", A_OPT, 32'hff);
    rd_chk("intctl", A_INT, 32'h0);
    chk("pullup_en", 32'h0, pullup_en);
    apb(1'b0, 12'h100, 32'h0);
    chk("pslverr", 32'h1, rerr);
    // Random control values read back; model of the core request
    repeat (6) begin
      mv = $random(seed);
      exp_q.push_back(mv);
      apb(1'b1, A_INT, mv);
      rd_chk("intctl", A_INT, exp_q.pop_front());
      chk("core_irq", mv[7] & |(mv[5:3] & mv[2:0]), core_irq);
    end
    apb(1'b1, A_INT, 32'h0);
    // Pull-ups follow the latch only while the disable bit is clear
    repeat (3) begin
      port_b_latch <= $random(seed);
      apb(1'b1, A_OPT, 32'h7f);
      repeat (2) @(posedge pclk);
      chk("pullup_en", port_b_latch, pullup_en);
      apb(1'b1, A_OPT, 32'hff);
      repeat (2) @(posedge pclk);
      chk("pullup_en", 32'h0, pullup_en);
    end
    // Pin clocking: one count per pulse
    apb(1'b1, A_TMR, 32'h0);
    P.pin_pulses(5);
    repeat (8) @(posedge pclk);
    rd_chk("timer", A_TMR, 32'h5);
    // Rising-edge selection counts the low-to-high transitions instead
    apb(1'b1, A_OPT, 32'hef);
    apb(1'b1, A_TMR, 32'h0);
    P.pin_pulses(3);
    repeat (8) @(posedge pclk);
    rd_chk("timer_rise", A_TMR, 32'h3);
    // Internal clock, prescaler on the watchdog: one count per cycle
    apb(1'b1, A_OPT, 32'h08);
    apb(1'b0, A_TMR, 32'h0); v1 = rdat; t1 = rtime;
    apb(1'b0, A_TMR, 32'h0);
    chk("timer_1to1", 32'h0, (t1 + rdat - v1 - rtime) & 8'hff);
    // Clock enable low for ten edges: the timer must lose exactly ten counts
    v1 = rdat; t1 = rtime;
    @(posedge pclk);
    ce <= 1'b0;
    repeat (10) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, A_TMR, 32'h0);
    chk("timer_ce", (rtime - t1 - 10) & 8'hff, (rdat - v1) & 8'hff);
    // Prescaler on the timer: one count per 2^(rate+1) cycles
    for (r = 0; r < 3; r++) begin
      apb(1'b1, A_OPT, r);
      apb(1'b0, A_TMR, 32'h0); v1 = rdat; t1 = rtime;
      repeat (40) @(posedge pclk);
      apb(1'b0, A_TMR, 32'h0);
      dt = (rtime - t1) >> (r + 1); d = (rdat - v1) & 8'hff;
      chk("timer_rate", 32'h1, (d == dt) || (d == dt + 1));
    end
    // Watchdog division: 128 ticks give 128 >> rate pulses
    for (r = 0; r < 8; r++) begin
      apb(1'b1, A_OPT, 8'h08 | r);
      n0 = wdt_cnt;
      P.ticks(128);
      repeat (4) @(posedge pclk);
      chk("wdt_div", 128 >> r, wdt_cnt - n0);
    end
    // Each source sets its flag and status with every core enable off and the status mask open
    apb(1'b1, A_MK, 32'hf);
    for (i = 0; i < 4; i++) begin
      case (i)
        0: begin apb(1'b1, A_OPT, 32'h08); apb(1'b1, A_TMR, 32'hfc); end
        1: P.set_pins(1'b1, 4'h0);
        2: P.set_pins(1'b1, 4'h5);
        default: P.cmp_pulse();
      endcase
      repeat (8) @(posedge pclk);
      if (i == 0) apb(1'b1, A_OPT, 32'hff);
      rd_chk("status", A_ST, 32'h1 << i);
      chk("irq", 32'h1, irq);
      chk("core_irq", 32'h0, core_irq);
      if (i < 3) rd_chk("intflag", A_INT, 32'h4 >> i);
      else rd_chk("cmpflag", A_PF, 32'h1);
      apb(1'b1, A_ST, 32'h1 << i);
      apb(1'b1, A_INT, 32'h0);
      apb(1'b1, A_PF, 32'h0);
      rd_chk("status", A_ST, 32'h0);
      chk("irq", 32'h0, irq);
    end
    // Comparator path: separate enable, global enable gates the core request
    apb(1'b1, A_PE, 32'h1);
    rd_chk("cmp_en", A_PE, 32'h1);
    apb(1'b1, A_MK, 32'h0);
    apb(1'b1, A_INT, 32'h40);
    P.cmp_pulse();
    repeat (2) @(posedge pclk);
    chk("core_irq", 32'h0, core_irq);
    chk("irq_masked", 32'h0, irq);
    apb(1'b1, A_INT, 32'hc0);
    repeat (2) @(posedge pclk);
    chk("core_irq", 32'h1, core_irq);
    apb(1'b1, A_PF, 32'h0);
    repeat (2) @(posedge pclk);
    chk("core_irq", 32'h0, core_irq);
    print_verdict();
  end
endmodule
